// file: hdl/pwm_auto_reload_timer.sv
// Overview of operation
// RULE1 - an 8-bit up-counter advances on each prescaler output tick while running
// RULE2 - on overflow the counter loads the reload value, prescaler left alone
// RULE3 - software reads or overwrites the live counter through the counter access register
// RULE4 - a 7-bit prescaler with eight taps divides by two to the power n
// RULE5 - the external clock select bit picks cpu clock or the external input
// RULE6 - with run enable clear, prescaler and counter stay frozen
// RULE7 - reset clears counter and prescaler and selects the cpu clock
// RULE8 - force reload with run, or a counter write, clears the hidden prescaler
// RULE9 - four hidden compare registers load from duty values only at overflow
// RULE10 - pwm generation stops while the microcontroller is halted
// RULE11 - a set output enable drives the channel pin as push-pull pwm output
// RULE12 - all channels share one frequency, counter clock over 256 minus reload
// RULE13 - each overflow sets every pwm pin to its polarity-given level
// RULE14 - counting past a channel's compare value restores the opposite pin level
// RULE15 - software keeps compare values above the reload value for a waveform
// RULE16 - duty resolution is one part in 256 minus reload value
// RULE17 - overflow sets a sticky flag and requests an interrupt when enabled
// RULE18 - with external clock, reload value sets events counted before overflow
// RULE19 - the overflow request can wake the microcontroller from wait and halt
// RULE20 - reading the control and status register clears the overflow flag
// RULE21 - the force reload bit is write-only and reads as zero
// RULE22 - polarity zero gives high while counter at or below compare, one inverts
// RULE23 - in halt with external clock, control is frozen but counting continues
// RULE24 - pins, flag and compare loads change on the counter edge causing them
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps

module pwm_auto_reload_timer #(
  parameter int N_CH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [art_pkg::ADDR_W-1:0] paddr,
  input wire logic [art_pkg::DATA_W-1:0] pwdata,
  output logic [art_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // board and system side
  input wire logic external_input_clock,
  input wire logic halt_mode,
  input wire logic wait_mode,
  // outputs
  output logic [N_CH-1:0] pwm_output,
  output logic [N_CH-1:0] pwm_pin_oe,
  output logic overflow_irq,
  output logic wake_req
);

  // refuse channel counts that the control register layout cannot hold
  if (N_CH < 1 || N_CH > art_pkg::MAX_CH) begin : g_bad_ch
    $error("N_CH must lie between 1 and 4");
  end

  typedef enum logic {
    APB_IDLE,
    APB_ACK
  } apb_state_t;

  // map a byte address onto a register index
  function automatic art_pkg::reg_sel_t decode(input logic [art_pkg::ADDR_W-1:0] a);
    art_pkg::reg_sel_t r;
    r = art_pkg::REG_NONE;
    if (a == art_pkg::OFF_CSR) r = art_pkg::REG_CSR;
    else if (a == art_pkg::OFF_CAR) r = art_pkg::REG_CAR;
    else if (a == art_pkg::OFF_ARR) r = art_pkg::REG_ARR;
    else if (a == art_pkg::OFF_PWM_CONTROL_REG) r = art_pkg::REG_PWM_CONTROL_REG;
    else if (a[11:4] == art_pkg::OFF_DCR0[11:4] && a[1:0] == 2'h0 && int'(a[3:2]) < N_CH)
      r = art_pkg::reg_sel_t'(4'(int'(art_pkg::REG_DCR0) + int'(a[3:2])));
    return r;
  endfunction : decode

  // true when the selected prescaler tap fires on this input tick
  function automatic logic tap_hit(input logic [6:0] pre, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    return &(pre | ~mask);
  endfunction : tap_hit

  ////////////////////////////////////////////////////////////////////////////
  // state
  art_pkg::ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] arr_r, arr_nxt;
  logic [7:0] pwm_control_reg_r, pwm_control_reg_nxt;
  logic [7:0] dcr_r [N_CH], dcr_nxt [N_CH];
  logic [7:0] cmp_r [N_CH], cmp_nxt [N_CH];
  logic [7:0] cnt_r, cnt_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic flag_r, flag_nxt;
  logic ext_q_r;
  apb_state_t apb_r, apb_nxt;
  logic [art_pkg::DATA_W-1:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [N_CH-1:0] pwm_nxt, oe_nxt;
  logic irq_nxt, wake_nxt;

  // decoded bus events
  art_pkg::reg_sel_t sel;
  logic acc_done, wr_ok, rd_csr_done, sw_cnt_wr;
  logic in_tick, cnt_tick, ovf;

  ////////////////////////////////////////////////////////////////////////////
  // bus event decode; writes are refused while halted so control stays frozen
  assign sel = decode(paddr);
  assign acc_done = psel && penable && pready;
  // RULE23 control frozen
  assign wr_ok = acc_done && pwrite && !pslverr && !halt_mode;
  // RULE20 read clears flag
  assign rd_csr_done = acc_done && !pwrite && sel == art_pkg::REG_CSR;
  // RULE8 prescaler clear sources
  assign sw_cnt_wr = wr_ok && (sel == art_pkg::REG_CAR ||
    (sel == art_pkg::REG_CSR && pwdata[art_pkg::CSR_FRL_BIT] && pwdata[art_pkg::CSR_RUN_BIT]));

  ////////////////////////////////////////////////////////////////////////////
  // clock source and prescaler ticks; the cpu clock is stopped in halt
  // RULE5 input clock select
  // RULE18 event counting
  assign in_tick = ctrl_r.ext_sel ? (external_input_clock && !ext_q_r) : !halt_mode;
  // RULE4 prescaler tap
  assign cnt_tick = ctrl_r.run && in_tick && tap_hit(pre_r, ctrl_r.tap);
  assign ovf = cnt_tick && cnt_r == art_pkg::CNT_MAX;

  ////////////////////////////////////////////////////////////////////////////
  // software-owned registers: next values
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    arr_nxt = arr_r;
    pwm_control_reg_nxt = pwm_control_reg_r;
    dcr_nxt = dcr_r;
    if (wr_ok)
    begin
      case (sel)
        art_pkg::REG_CSR:
        begin
          ctrl_nxt.ext_sel = pwdata[art_pkg::CSR_EXT_BIT];
          ctrl_nxt.tap = pwdata[art_pkg::CSR_TAP_LSB +: art_pkg::TAP_W];
          ctrl_nxt.run = pwdata[art_pkg::CSR_RUN_BIT];
          ctrl_nxt.irq_en = pwdata[art_pkg::CSR_IRQ_BIT];
        end
        art_pkg::REG_ARR: arr_nxt = pwdata[7:0];
        art_pkg::REG_PWM_CONTROL_REG: pwm_control_reg_nxt = pwdata[7:0];
        art_pkg::REG_DCR0, art_pkg::REG_DCR1, art_pkg::REG_DCR2, art_pkg::REG_DCR3:
          dcr_nxt[int'(sel) - int'(art_pkg::REG_DCR0)] = pwdata[7:0];
        default: ;
      endcase
    end
  end

  // software-owned registers: storage
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // RULE7 cpu clock after reset
      ctrl_r <= art_pkg::CTRL_RST;
      arr_r <= art_pkg::RST_BYTE;
      pwm_control_reg_r <= art_pkg::RST_BYTE;
      for (int i = 0; i < N_CH; i++) dcr_r[i] <= art_pkg::RST_BYTE;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      arr_r <= arr_nxt;
      pwm_control_reg_r <= pwm_control_reg_nxt;
      dcr_r <= dcr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, prescaler, compare shadows and flag: next values
  always_comb
  begin
    cnt_nxt = cnt_r;
    pre_nxt = pre_r;
    cmp_nxt = cmp_r;
    flag_nxt = flag_r;
    // RULE6 frozen unless running
    if (ctrl_r.run && in_tick) pre_nxt = 7'(pre_r + 7'h01);
    // RULE1 count up
    if (cnt_tick) cnt_nxt = 8'(cnt_r + 8'h01);
    // RULE2 auto reload
    // RULE12 period from reload
    if (ovf) cnt_nxt = arr_r;
    // RULE9 shadow load
    if (ovf) cmp_nxt = dcr_r;
    // a read only clears the flag it actually returned, so a set is never lost
    if (rd_csr_done && prdata[art_pkg::CSR_OVF_BIT]) flag_nxt = 1'b0;
    // RULE17 sticky flag
    if (ovf) flag_nxt = 1'b1;
    // RULE3 counter written on the fly
    if (wr_ok && sel == art_pkg::REG_CAR) cnt_nxt = pwdata[7:0];
    else if (sw_cnt_wr) cnt_nxt = arr_r;
    // RULE8 prescaler cleared
    if (sw_cnt_wr) pre_nxt = art_pkg::RST_PRE;
  end

  // timer storage; the external input is sampled once for its edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // RULE7 counter and prescaler cleared
      cnt_r <= art_pkg::RST_BYTE;
      pre_r <= art_pkg::RST_PRE;
      for (int i = 0; i < N_CH; i++) cmp_r[i] <= art_pkg::RST_BYTE;
      flag_r <= 1'b0;
      ext_q_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      cmp_r <= cmp_nxt;
      flag_r <= flag_nxt;
      ext_q_r <= external_input_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin levels follow the next counter value, so overflow and compare edges land
  // on the same clock as the counter event and a polarity write acts at once
  // RULE24 same-edge update
  always_comb
  begin
    for (int i = 0; i < N_CH; i++)
    begin
      // RULE11 pin enable
      oe_nxt[i] = pwm_control_reg_nxt[art_pkg::PWM_CONTROL_REG_OE_LSB + i];
      // RULE22 level against compare
      // RULE14 compare restores level
      // RULE16 one step per count
      // RULE10 halt stops pwm
      pwm_nxt[i] = oe_nxt[i] && !halt_mode &&
        ((cnt_nxt <= cmp_nxt[i]) ^ pwm_control_reg_nxt[art_pkg::PWM_CONTROL_REG_POL_LSB + i]);
    end
    irq_nxt = flag_nxt && ctrl_nxt.irq_en;
    // RULE19 wake from low power
    wake_nxt = irq_nxt && (halt_mode || wait_mode);
  end

  // output registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwm_output <= '0;
      pwm_pin_oe <= '0;
      overflow_irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      // RULE13 levels set at overflow
      pwm_output <= pwm_nxt;
      pwm_pin_oe <= oe_nxt;
      overflow_irq <= irq_nxt;
      wake_req <= wake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: data is sampled in the setup cycle, one access cycle always
  always_comb
  begin
    apb_nxt = apb_r;
    prdata_nxt = '0;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    case (apb_r)
      APB_IDLE:
      begin
        if (psel && !penable)
        begin
          apb_nxt = APB_ACK;
          pready_nxt = 1'b1;
          pslverr_nxt = (sel == art_pkg::REG_NONE);
          case (sel)
            // RULE21 force reload reads zero
            art_pkg::REG_CSR: prdata_nxt[7:0] = {ctrl_r.ext_sel, ctrl_r.tap, ctrl_r.run, 1'b0,
              ctrl_r.irq_en, flag_r};
            art_pkg::REG_CAR: prdata_nxt[7:0] = cnt_r;
            art_pkg::REG_ARR: prdata_nxt[7:0] = arr_r;
            art_pkg::REG_PWM_CONTROL_REG: prdata_nxt[7:0] = pwm_control_reg_r;
            art_pkg::REG_DCR0, art_pkg::REG_DCR1, art_pkg::REG_DCR2, art_pkg::REG_DCR3:
              prdata_nxt[7:0] = dcr_r[int'(sel) - int'(art_pkg::REG_DCR0)];
            default: prdata_nxt = '0;
          endcase
        end
      end
      APB_ACK:
      begin
        apb_nxt = APB_IDLE;
      end
      default: apb_nxt = APB_IDLE;
    endcase
  end

  // apb storage
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      apb_r <= APB_IDLE;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      apb_r <= apb_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_count_up;
    @(posedge core_clk) disable iff (!resetn)
    cnt_tick && cnt_r != art_pkg::CNT_MAX && !sw_cnt_wr |=> cnt_r == 8'($past(cnt_r) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step by one"); // RULE1

  property p_reload;
    @(posedge core_clk) disable iff (!resetn)
    ovf && !sw_cnt_wr |=> cnt_r == $past(arr_r) && pre_r == 7'($past(pre_r) + 7'h01);
  endproperty
  a_reload: assert property (p_reload) else $error("overflow did not reload or touched prescaler"); // RULE2

  property p_frozen;
    @(posedge core_clk) disable iff (!resetn)
    !ctrl_r.run && !sw_cnt_wr |=> $stable(cnt_r) && $stable(pre_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("timer moved while stopped"); // RULE6

  property p_pre_clear;
    @(posedge core_clk) disable iff (!resetn)
    sw_cnt_wr |=> pre_r == art_pkg::RST_PRE;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared"); // RULE8

  property p_car_write;
    @(posedge core_clk) disable iff (!resetn)
    wr_ok && sel == art_pkg::REG_CAR |=> cnt_r == $past(pwdata[7:0]);
  endproperty
  a_car_write: assert property (p_car_write) else $error("counter write lost"); // RULE3

  property p_shadow;
    @(posedge core_clk) disable iff (!resetn)
    ovf |=> cmp_r[0] == $past(dcr_r[0]) ##1 ($past(ovf) || $stable(cmp_r[0]));
  endproperty
  a_shadow: assert property (p_shadow) else $error("compare shadow load wrong"); // RULE9

  property p_flag_set;
    @(posedge core_clk) disable iff (!resetn)
    ovf |=> flag_r && overflow_irq == ctrl_r.irq_en;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag or request missing"); // RULE17

  property p_flag_clear;
    @(posedge core_clk) disable iff (!resetn)
    rd_csr_done && prdata[art_pkg::CSR_OVF_BIT] && !ovf |=> !flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("status read did not clear flag"); // RULE20

  property p_frl_zero;
    @(posedge core_clk) disable iff (!resetn)
    psel && !penable && !pwrite && sel == art_pkg::REG_CSR |=> pready && !prdata[art_pkg::CSR_FRL_BIT];
  endproperty
  a_frl_zero: assert property (p_frl_zero) else $error("force reload read back set"); // RULE21

  property p_halt_pwm;
    @(posedge core_clk) disable iff (!resetn)
    halt_mode |=> pwm_output == '0;
  endproperty
  a_halt_pwm: assert property (p_halt_pwm) else $error("pwm active during halt"); // RULE10

  property p_level;
    @(posedge core_clk) disable iff (!resetn)
    !$past(halt_mode) |-> pwm_output[0] == (pwm_control_reg_r[art_pkg::PWM_CONTROL_REG_OE_LSB] &&
      ((cnt_r <= cmp_r[0]) ^ pwm_control_reg_r[art_pkg::PWM_CONTROL_REG_POL_LSB]));
  endproperty
  a_level: assert property (p_level) else $error("pwm level disagrees with compare"); // RULE22

  c_overflow: cover property (@(posedge core_clk) disable iff (!resetn) ovf ##1 overflow_irq);
  c_read_clear: cover property (@(posedge core_clk) disable iff (!resetn) rd_csr_done && flag_r);
  c_car_write: cover property (@(posedge core_clk) disable iff (!resetn) wr_ok && sel == art_pkg::REG_CAR);
  c_pwm_edge: cover property (@(posedge core_clk) disable iff (!resetn) $fell(pwm_output[0]));

endmodule : pwm_auto_reload_timer

// file: hdl/art_pkg.sv
package art_pkg;

  // widths of the timer datapath
  localparam int CNT_W = 8;
  localparam int PRE_W = 7;
  localparam int TAP_W = 3;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int MAX_CH = 4;

  // register byte offsets on the bus
  localparam logic [11:0] OFF_CSR = 12'h000;
  localparam logic [11:0] OFF_CAR = 12'h004;
  localparam logic [11:0] OFF_ARR = 12'h008;
  localparam logic [11:0] OFF_PWM_CONTROL_REG = 12'h00c;
  localparam logic [11:0] OFF_DCR0 = 12'h010;

  // control / status field positions
  localparam int CSR_EXT_BIT = 7;
  localparam int CSR_TAP_LSB = 4;
  localparam int CSR_RUN_BIT = 3;
  localparam int CSR_FRL_BIT = 2;
  localparam int CSR_IRQ_BIT = 1;
  localparam int CSR_OVF_BIT = 0;

  // pwm control field positions
  localparam int PWM_CONTROL_REG_OE_LSB = 4;
  localparam int PWM_CONTROL_REG_POL_LSB = 0;

  // reset values and counter limit
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_PRE = 7'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // register index returned by the address decoder
  typedef enum logic [3:0] {
    REG_CSR,
    REG_CAR,
    REG_ARR,
    REG_PWM_CONTROL_REG,
    REG_DCR0,
    REG_DCR1,
    REG_DCR2,
    REG_DCR3,
    REG_NONE
  } reg_sel_t;

  // software-owned timer control bits
  typedef struct packed {
    logic ext_sel;
    logic [2:0] tap;
    logic run;
    logic irq_en;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{ext_sel: 1'b0, tap: 3'h0, run: 1'b0, irq_en: 1'b0};

endpackage : art_pkg

// file: tb/pwm_auto_reload_timer_tb.sv
`timescale 1ns/10ps

module pwm_auto_reload_timer_tb;
  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observed outputs
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [art_pkg::ADDR_W-1:0] paddr = 12'h000;
  logic [art_pkg::DATA_W-1:0] pwdata = 32'h0;
  logic [art_pkg::DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_clk = 1'b0;
  logic halt = 1'b0;
  logic waitm = 1'b0;
  logic [3:0] pwm;
  logic [3:0] oe;
  logic irq;
  logic wake;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h56;
  logic [31:0] rd;
  logic err;
  logic [7:0] duty [4];

  pwm_auto_reload_timer #(.N_CH(4)) uut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_input_clock(ext_clk), .halt_mode(halt), .wait_mode(waitm), .pwm_output(pwm),
    .pwm_pin_oe(oe), .overflow_irq(irq), .wake_req(wake)
  );

  always #10 core_clk = ~core_clk;

  // hang guard, sized well above the slowest tap sweep
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input integer got, input integer exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_n

  // one transfer; pready and the answer are taken at the rising edge, before the slave's update lands
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // all channels enabled, irq on, forced reload so counting starts from a known place
  task automatic cfg(input logic [7:0] rl, input logic [2:0] tap, input logic [3:0] pol, input logic ext);
    apb(1'b1, art_pkg::OFF_ARR, {24'h0, rl});
    for (int i = 0; i < 4; i++) apb(1'b1, art_pkg::OFF_DCR0 + 12'(4 * i), {24'h0, duty[i]});
    apb(1'b1, art_pkg::OFF_PWM_CONTROL_REG, {24'h0, 4'hf, pol});
    apb(1'b1, art_pkg::OFF_CSR, {24'h0, ext, tap, 4'he});
  endtask : cfg

  task automatic wait_rise();
    logic p;
    p = pwm[0];
    @(negedge core_clk);
    while (!(p === 1'b0 && pwm[0] === 1'b1))
    begin
      p = pwm[0];
      @(negedge core_clk);
    end
  endtask : wait_rise

  // skip two periods so shadows hold the new duties, then time one full period
  task automatic meas(input logic [7:0] rl, input int tap, input logic [3:0] pol);
    int n;
    integer hi [4];
    int per;
    int h;
    logic p;
    n = 0;
    hi = '{0, 0, 0, 0};
    wait_rise();
    wait_rise();
    do
    begin
      for (int i = 0; i < 4; i++) hi[i] += pwm[i];
      n++;
      p = pwm[0];
      @(negedge core_clk);
    end while (!(p === 1'b0 && pwm[0] === 1'b1));
    per = (256 - int'(rl)) << tap;
    chk_n(n, per);
    chk(32'(oe), 32'hf);
    for (int i = 0; i < 4; i++)
    begin
      h = (int'(duty[i]) - int'(rl) + 1) << tap;
      chk_n(hi[i], pol[i] ? per - h : h);
    end
  endtask : meas

  // the event input is held several cycles so the synchronous sampler sees each level
  task automatic pulse();
    @(posedge core_clk);
    ext_clk <= 1'b1;
    repeat (3) @(posedge core_clk);
    ext_clk <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [7:0] rl;
    logic [2:0] tp;
    logic [3:0] pol;
    logic [31:0] r;
    logic [31:0] rd0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(art_pkg::OFF_CSR, 32'h0);
    rdc(art_pkg::OFF_CAR, 32'h0);
    rdc(art_pkg::OFF_ARR, 32'h0);
    rdc(art_pkg::OFF_PWM_CONTROL_REG, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, art_pkg::OFF_CAR, 32'h5a);
    rdc(art_pkg::OFF_CAR, 32'h5a);
    rdc(art_pkg::OFF_CAR, 32'h5a);
    apb(1'b1, art_pkg::OFF_CSR, 32'h08);
    apb(1'b0, art_pkg::OFF_CAR, 32'h0);
    rd0 = rd;
    apb(1'b0, art_pkg::OFF_CAR, 32'h0);
    chk(rd, rd0 + 32'h3);
    apb(1'b1, art_pkg::OFF_CSR, 32'h3c);
    apb(1'b0, art_pkg::OFF_CSR, 32'h0);
    chk(rd & 32'hfe, 32'h38);
    // every tap first, then random reloads; channel 0 keeps polarity 0 as the timing reference
    for (int t = 0; t < 14; t++)
    begin
      r = rnd();
      rl = (t < 8) ? (8'hf0 | {5'h0, r[2:0]}) : (8'hc0 | {3'h0, r[4:0]});
      tp = (t < 8) ? 3'(t) : {1'b0, r[9:8]};
      pol = {r[6:4], 1'b0};
      if (t == 8)
        rl = 8'h00;
      for (int i = 0; i < 4; i++) duty[i] = rl + 8'h01 + 8'(rnd() % (32'hfe - 32'(rl)));
      if (t == 8)
      begin
        duty[0] = 8'h01;
        duty[1] = 8'hfe;
      end
      cfg(rl, tp, pol, 1'b0);
      meas(rl, int'(tp), pol);
    end
    @(posedge core_clk);
    halt <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk(32'(pwm), 32'h0);
    apb(1'b0, art_pkg::OFF_CAR, 32'h0);
    rd0 = rd;
    apb(1'b0, art_pkg::OFF_CAR, 32'h0);
    chk(rd, rd0);
    apb(1'b1, art_pkg::OFF_ARR, 32'h11);
    rdc(art_pkg::OFF_ARR, {24'h0, rl});
    halt <= 1'b0;
    cfg(8'hfd, 3'h0, 4'h0, 1'b1);
    apb(1'b0, art_pkg::OFF_CSR, 32'h0);
    pulse();
    pulse();
    apb(1'b0, art_pkg::OFF_CSR, 32'h0);
    chk(rd & 32'h1, 32'h0);
    halt <= 1'b1;
    pulse();
    chk(32'(irq), 32'h1);
    chk(32'(wake), 32'h1);
    @(posedge core_clk);
    halt <= 1'b0;
    waitm <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk(32'(wake), 32'h1);
    @(posedge core_clk);
    waitm <= 1'b0;
    apb(1'b0, art_pkg::OFF_CSR, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b0, art_pkg::OFF_CSR, 32'h0);
    chk(rd & 32'h1, 32'h0);
    chk(32'(irq), 32'h0);
    final_report();
  end
endmodule : pwm_auto_reload_timer_tb
